// ---- logic/canmrx_filter.sv ----
// Purpose: one acceptance filter compare against the assembled message
// Assumes: identifiers are 29 bits, standard identifier in the top 11
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module canmrx_filter
	import canmrx_pkg::*;
(
	// Message under test
	input  wire logic [28:0] msg_id,
	input  wire logic        msg_ext,
	// Filter, mask and receive mode
	input  wire logic [28:0] flt_id,
	input  wire logic        flt_ext,
	input  wire logic [28:0] mask,
	input  wire logic [1:0]  rx_mode,
	// Result
	output logic             hit
);
	logic        type_ok;
	logic [28:0] care;

	always_comb begin
		unique case (rx_mode)
			2'h0: type_ok = (msg_ext == flt_ext);
			2'h1: type_ok = !msg_ext;
			2'h2: type_ok = msg_ext;
			default: type_ok = 1'b1;
		endcase
	end

	// Standard frames carry no extended bits, so those never take part
	assign care = msg_ext ? mask : {mask[28:STD_LSB], 18'h00000};
	assign hit  = (rx_mode == 2'h3) || (type_ok && (((msg_id ^ flt_id) & care) == 29'h0));
endmodule : canmrx_filter
`default_nettype wire

// ---- logic/canmrx_pkg.sv ----
// Purpose: constants, register map and mode codes for the CAN mode/receive/priority block
// Assumes: 10 MHz pclk, APB register access, 32-bit data, byte addresses
// Notes:   shared by canmrx_top and canmrx_filter
// What this block does
// - Disabled: no traffic, pins released, wake flag still set, flags and count kept.
// - Disable request waits for eleven recessive bits, then reports disable mode.
// - Config bit enables glitch filter on receive line during disable or sleep.
// - Early transmit waits eleven idle bits; disable meanwhile aborts it and drops request.
// - Normal mode owns both bus pins and sends and receives on them.
// - Listen-only releases transmit pin, sends no flags, freezes the error counter.
// - Listen-all ignores errors and copies assembly contents into a readable buffer.
// - Loopback ties internal transmit to internal receive and releases both pins.
// - Hidden assembly buffer watches the bus; outside listen-all only filtered messages reach buffers.
// - Hardware sets receive flag on load, software clears it, enable raises interrupt.
// - Filters zero, one and mask zero feed buffer zero; the rest buffer one.
// - Frame type must match filter type unless receive mode field overrides.
// - A zero mask bit makes that identifier bit always match.
// - Accepted message for a full buffer sets overrun and error summary, is dropped.
// - Without double buffering a full buffer zero never spills into buffer one.
// - With double buffering buffer zero spills into empty buffer one, else overrun one.
// - Receive errors count up; warning at 96, passive beyond 127.
// - Receive flag rises right after end of frame of an accepted message.
// - Wake interrupt on bus activity while disabled or on leaving sleep.
// - A receive error in any active mode (not disable or init) sets invalid-message flag and error summary.
// - Three transmit buffers of sixteen bytes: eight payload, rest identifier and control.
// - Two-bit transmit priority, highest pending buffer is offered first.
// - Three-bit requested mode; current mode follows only when change is acceptable.
package canmrx_pkg;
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned WAKE_FILT_NS   = 500;
	localparam int unsigned WAKE_FILT_CYC  = (WAKE_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0]  WAKE_FILT_LAST = 4'(WAKE_FILT_CYC - 1);
	localparam logic [3:0]  IDLE_BITS      = 4'hB;
	localparam logic [7:0]  WARN_LIMIT     = 8'h60;
	localparam logic [7:0]  PASSIVE_LIMIT  = 8'h7F;
	localparam logic [7:0]  BIT_DIV_RST    = 8'h09;

	// Register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CFG_ADDR  = 8'h04;
	localparam logic [7:0] INTF_ADDR = 8'h08;
	localparam logic [7:0] INTE_ADDR = 8'h0C;
	localparam logic [7:0] REC_ADDR  = 8'h10;
	localparam logic [2:0] FLT_HI    = 3'h1;
	localparam logic [4:0] MASK_HI   = 5'h07;
	localparam logic [2:0] RXB_HI    = 3'h2;
	localparam logic [1:0] TXB_HI    = 2'h2;

	// Field positions
	localparam int CTRL_REQ_LSB = 8;
	localparam int CTRL_CUR_LSB = 5;
	localparam int CFG_WAKE_FILTER_ENABLE   = 14;
	localparam int CFG_DOUBLE_BUFFER_ENABLE     = 12;
	localparam int CFG_ACCEPT_MASK_ONE_LSB = 10;
	localparam int CFG_ACCEPT_MASK_ZERO_LSB = 8;
	localparam int INT_RX0      = 0;
	localparam int INT_RX1      = 1;
	localparam int INT_ERR      = 5;
	localparam int INT_WAKE     = 6;
	localparam int INT_IVR      = 7;
	localparam int INT_RX_WARNING_FLAG    = 9;
	localparam int INT_RX_PASSIVE_FLAG     = 11;
	localparam int INT_OVR1     = 14;
	localparam int INT_OVR0     = 15;
	localparam int ID_EXT       = 29;
	localparam int TXC_REQ      = 3;
	localparam int TXC_ABT      = 6;
	localparam int TXC_ARB_LSB  = 16;
	localparam int STD_LSB      = 18;

	typedef enum logic [2:0] {
		MODE_NORMAL     = 3'b000,
		MODE_DISABLE    = 3'b001,
		MODE_LOOPBACK   = 3'b010,
		MODE_LISTEN     = 3'b011,
		MODE_INIT       = 3'b100,
		MODE_LISTEN_ALL = 3'b111
	} canmrx_mode_t;

	function automatic logic canmrx_legal(input logic [2:0] code);
		return (code != 3'h5) && (code != 3'h6);
	endfunction : canmrx_legal

	function automatic logic canmrx_tx_mode(input logic [2:0] code);
		return (code == MODE_NORMAL) || (code == MODE_LOOPBACK);
	endfunction : canmrx_tx_mode
endpackage : canmrx_pkg

// ---- logic/canmrx_top.sv ----
// Purpose: CAN mode control, receive buffering and filtering, transmit buffer priority
// Assumes: protocol engine outside decodes bits and drives the eng_* signals on pclk
// Notes:   APB slave with zero wait states
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module canmrx_top
	import canmrx_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Bus pins
	input  wire logic        can_rx_pin,
	output logic             can_tx_pin_o,
	output logic             can_tx_pin_oe_n,
	output logic             tx_pin_is_can,
	output logic             rx_pin_is_can,
	// Power state
	input  wire logic        cpu_sleep,
	// Protocol engine
	input  wire logic        eng_tx_bit,
	output logic             eng_rx_bit,
	output logic             eng_passive,
	input  wire logic        eng_asm_we,
	input  wire logic [28:0] eng_asm_id,
	input  wire logic        eng_asm_ext,
	input  wire logic [63:0] eng_asm_data,
	input  wire logic        eng_frame_done,
	input  wire logic        eng_rx_err,
	input  wire logic        eng_tx_done,
	input  wire logic [1:0]  eng_tx_done_idx,
	output logic             tx_sel_valid,
	output logic [1:0]       tx_sel_idx,
	output logic             tx_start_ok,
	// Interrupt lines
	output logic             rx0_irq,
	output logic             rx1_irq,
	output logic             err_irq,
	output logic             wake_irq
);
	canmrx_mode_t cur_op_ff;
	logic [2:0]  req_op_ff;
	logic        wake_filter_enable_ff, double_buffer_enable_ff;
	logic [1:0]  rxm_ff [2];
	logic [7:0]  bit_div_ff, div_cnt_ff, rec_ff;
	logic [1:0]  rxf_ff, ovr_ff;
	logic        error_summary_flag_ff, wake_flag_ff, invalid_msg_flag_ff;
	logic [3:0]  inte_ff, idle_cnt_ff, wf_cnt_ff;
	logic [28:0] flt_id_ff [6];
	logic [5:0]  flt_ext_ff;
	logic [28:0] mask_ff [2];
	logic [28:0] asm_id_ff;
	logic        asm_ext_ff;
	logic [63:0] asm_data_ff;
	logic [28:0] rxb_id_ff [2];
	logic [1:0]  rxb_ext_ff;
	logic [63:0] rxb_data_ff [2];
	logic [31:0] txw_ff [3][3];
	logic [15:0] tx_arb_ff [3];
	logic [1:0]  tx_pri_ff [3];
	logic [2:0]  tx_req_ff, tx_abt_ff;
	logic        rx_s1_ff, rx_s2_ff, tx_hold_ff, sleep_d_ff, tx_pin_ff;
	logic [31:0] prdata_ff, rdata;
	logic        addr_hit, apb_wr, bit_tick, rx_line, bus_idle, mode_go, active;
	logic        listen_all, accept, hit0, hit1, load0, load1, set_ovr0, set_ovr1;
	logic        count_en, rec_inc, warn_rise, wake_watch, wake_act, sleep_exit, abort_now;
	logic        intf_wr, sel_v;
	logic [5:0]  f_hit;
	logic [1:0]  sel_i, sel_p;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus input synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
		end else begin
			rx_s1_ff <= can_rx_pin;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	assign active     = (cur_op_ff != MODE_DISABLE) && (cur_op_ff != MODE_INIT);
	assign listen_all = (cur_op_ff == MODE_LISTEN_ALL);
	assign bit_tick   = (div_cnt_ff >= bit_div_ff);

	// Nominal bit rate enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_cnt_ff <= 8'h00;
		else if (bit_tick)
			div_cnt_ff <= 8'h00;
		else
			div_cnt_ff <= div_cnt_ff + 8'h01;
	end

	// Idle detect: eleven recessive bits on the line the engine sees
	assign rx_line  = (cur_op_ff == MODE_LOOPBACK) ? eng_tx_bit : rx_s2_ff;
	assign bus_idle = (idle_cnt_ff == IDLE_BITS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_cnt_ff <= 4'h0;
		else if (mode_go)
			idle_cnt_ff <= 4'h0;
		else if (bit_tick && !rx_line)
			idle_cnt_ff <= 4'h0;
		else if (bit_tick && !bus_idle)
			idle_cnt_ff <= idle_cnt_ff + 4'h1;
	end

	// Inactive modes may switch at once; active ones only on an idle bus
	assign mode_go = canmrx_legal(req_op_ff) && (req_op_ff != cur_op_ff)
		&& (bus_idle || !active);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cur_op_ff <= MODE_INIT;
		else if (mode_go)
			cur_op_ff <= canmrx_mode_t'(req_op_ff);
	end

	dis_wait_a: assert property ($changed(cur_op_ff) && (cur_op_ff == MODE_DISABLE)
		&& $past(active) |-> $past(bus_idle))
		else $error("disable entered without idle bus");

	// Transmit hold after entering a transmitting mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_hold_ff <= 1'b0;
		else if (mode_go)
			tx_hold_ff <= canmrx_tx_mode(req_op_ff);
		else if (bus_idle)
			tx_hold_ff <= 1'b0;
	end

	assign abort_now = tx_hold_ff && (req_op_ff == MODE_DISABLE);

	// Pin ownership
	assign tx_pin_is_can   = (cur_op_ff == MODE_NORMAL);
	assign rx_pin_is_can   = tx_pin_is_can || (cur_op_ff == MODE_LISTEN) || listen_all;
	assign can_tx_pin_oe_n = !tx_pin_is_can;
	assign can_tx_pin_o    = tx_pin_ff;
	assign eng_passive     = (cur_op_ff == MODE_LISTEN) || listen_all;
	assign eng_rx_bit      = (cur_op_ff == MODE_LOOPBACK) ? eng_tx_bit
		: (rx_pin_is_can ? rx_s2_ff : 1'b1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_pin_ff <= 1'b1;
		else
			tx_pin_ff <= tx_pin_is_can ? eng_tx_bit : 1'b1;
	end

	tx_release_a: assert property ((cur_op_ff != MODE_NORMAL) [*2] |-> can_tx_pin_o
		&& can_tx_pin_oe_n)
		else $error("transmit pin driven outside normal mode");
	loop_route_a: assert property ((cur_op_ff == MODE_LOOPBACK) |-> (eng_rx_bit == eng_tx_bit)
		&& !tx_pin_is_can && !rx_pin_is_can)
		else $error("loopback routing broken");

	// APB slave
	assign pready  = 1'b1;
	assign apb_wr  = psel && penable && pwrite && addr_hit;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata  = prdata_ff;
	assign intf_wr = apb_wr && (paddr == INTF_ADDR);

	always_comb begin
		rdata    = 32'h0;
		addr_hit = 1'b1;
		if (paddr == CTRL_ADDR) begin
			rdata[CTRL_REQ_LSB +: 3] = req_op_ff;
			rdata[CTRL_CUR_LSB +: 3] = cur_op_ff;
		end else if (paddr == CFG_ADDR) begin
			rdata[CFG_WAKE_FILTER_ENABLE] = wake_filter_enable_ff;
			rdata[CFG_DOUBLE_BUFFER_ENABLE] = double_buffer_enable_ff;
			rdata[CFG_ACCEPT_MASK_ONE_LSB +: 2] = rxm_ff[1];
			rdata[CFG_ACCEPT_MASK_ZERO_LSB +: 2] = rxm_ff[0];
			rdata[7:0] = bit_div_ff;
		end else if (paddr == INTF_ADDR) begin
			rdata[INT_RX1:INT_RX0] = rxf_ff;
			rdata[INT_ERR] = error_summary_flag_ff;
			rdata[INT_WAKE] = wake_flag_ff;
			rdata[INT_IVR] = invalid_msg_flag_ff;
			rdata[INT_RX_WARNING_FLAG] = (rec_ff >= WARN_LIMIT);
			rdata[INT_RX_PASSIVE_FLAG] = (rec_ff > PASSIVE_LIMIT);
			rdata[INT_OVR1] = ovr_ff[1];
			rdata[INT_OVR0] = ovr_ff[0];
		end else if (paddr == INTE_ADDR) begin
			rdata[INT_RX1:INT_RX0] = inte_ff[1:0];
			rdata[INT_ERR] = inte_ff[2];
			rdata[INT_WAKE] = inte_ff[3];
		end else if (paddr == REC_ADDR) begin
			rdata[7:0] = rec_ff;
		end else if (paddr[7:5] == FLT_HI && paddr[4:2] < 3'h6 && paddr[1:0] == 2'h0) begin
			rdata = {2'h0, flt_ext_ff[paddr[4:2]], flt_id_ff[paddr[4:2]]};
		end else if (paddr[7:3] == MASK_HI && paddr[1:0] == 2'h0) begin
			rdata = {3'h0, mask_ff[paddr[2]]};
		end else if (paddr[7:5] == RXB_HI && paddr[3:2] != 2'h3 && paddr[1:0] == 2'h0) begin
			unique case (paddr[3:2])
				2'h0: rdata = {2'h0, rxb_ext_ff[paddr[4]], rxb_id_ff[paddr[4]]};
				2'h1: rdata = rxb_data_ff[paddr[4]][31:0];
				default: rdata = rxb_data_ff[paddr[4]][63:32];
			endcase
		end else if (paddr[7:6] == TXB_HI && paddr[5:4] != 2'h3 && paddr[1:0] == 2'h0) begin
			if (paddr[3:2] == 2'h0) begin
				rdata[TXC_ARB_LSB +: 16] = tx_arb_ff[paddr[5:4]];
				rdata[TXC_ABT] = tx_abt_ff[paddr[5:4]];
				rdata[TXC_REQ] = tx_req_ff[paddr[5:4]];
				rdata[1:0] = tx_pri_ff[paddr[5:4]];
			end else begin
				rdata = txw_ff[paddr[5:4]][paddr[3:2] - 2'h1];
			end
		end else begin
			addr_hit = 1'b0;
		end
	end

	// Read data captured in the setup cycle, presented during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata_ff <= rdata;
	end

	// Control, configuration and enable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_op_ff <= MODE_INIT;
			wake_filter_enable_ff <= 1'b0;
			double_buffer_enable_ff <= 1'b0;
			rxm_ff[0] <= 2'h0;
			rxm_ff[1] <= 2'h0;
			bit_div_ff <= BIT_DIV_RST;
			inte_ff <= 4'h0;
		end else if (apb_wr) begin
			if (paddr == CTRL_ADDR)
				req_op_ff <= pwdata[CTRL_REQ_LSB +: 3];
			if (paddr == CFG_ADDR) begin
				wake_filter_enable_ff <= pwdata[CFG_WAKE_FILTER_ENABLE];
				double_buffer_enable_ff <= pwdata[CFG_DOUBLE_BUFFER_ENABLE];
				rxm_ff[1] <= pwdata[CFG_ACCEPT_MASK_ONE_LSB +: 2];
				rxm_ff[0] <= pwdata[CFG_ACCEPT_MASK_ZERO_LSB +: 2];
				bit_div_ff <= pwdata[7:0];
			end
			if (paddr == INTE_ADDR)
				inte_ff <= {pwdata[INT_WAKE], pwdata[INT_ERR], pwdata[INT_RX1:INT_RX0]};
		end
	end

	// Filters and masks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 6; i++)
				flt_id_ff[i] <= 29'h0;
			flt_ext_ff <= 6'h00;
			mask_ff[0] <= 29'h0;
			mask_ff[1] <= 29'h0;
		end else if (apb_wr && paddr[7:5] == FLT_HI && paddr[4:2] < 3'h6) begin
			// Mask words sit in the top of the filter window
			flt_id_ff[paddr[4:2]] <= pwdata[28:0];
			flt_ext_ff[paddr[4:2]] <= pwdata[ID_EXT];
		end else if (apb_wr && paddr[7:3] == MASK_HI) begin
			mask_ff[paddr[2]] <= pwdata[28:0];
		end
	end

	// Assembly buffer follows the engine whenever the controller listens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asm_id_ff <= 29'h0;
			asm_ext_ff <= 1'b0;
			asm_data_ff <= 64'h0;
		end else if (eng_asm_we && active) begin
			asm_id_ff <= eng_asm_id;
			asm_ext_ff <= eng_asm_ext;
			asm_data_ff <= eng_asm_data;
		end
	end

	for (genvar g = 0; g < 6; g++) begin : g_flt
		canmrx_filter u_flt (
			.msg_id  (asm_id_ff),
			.msg_ext (asm_ext_ff),
			.flt_id  (flt_id_ff[g]),
			.flt_ext (flt_ext_ff[g]),
			.mask    (mask_ff[(g < 2) ? 0 : 1]),
			.rx_mode (rxm_ff[(g < 2) ? 0 : 1]),
			.hit     (f_hit[g])
		);
	end

	// Listen-all takes even a broken message into buffer zero
	assign accept = active && (eng_frame_done || (listen_all && eng_rx_err));
	assign hit0   = listen_all || f_hit[0] || f_hit[1];
	assign hit1   = |f_hit[5:2];

	always_comb begin
		load0 = 1'b0;
		load1 = 1'b0;
		set_ovr0 = 1'b0;
		set_ovr1 = 1'b0;
		if (accept && hit0) begin
			if (!rxf_ff[0])
				load0 = 1'b1;
			else if (double_buffer_enable_ff && !rxf_ff[1])
				load1 = 1'b1;
			else if (double_buffer_enable_ff)
				set_ovr1 = 1'b1;
			else
				set_ovr0 = 1'b1;
		end else if (accept && hit1) begin
			if (!rxf_ff[1])
				load1 = 1'b1;
			else
				set_ovr1 = 1'b1;
		end
	end

	// Visible receive buffers keep contents on overrun
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				rxb_id_ff[i] <= 29'h0;
				rxb_data_ff[i] <= 64'h0;
			end
			rxb_ext_ff <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? load0 : load1) begin
					rxb_id_ff[i] <= asm_id_ff;
					rxb_ext_ff[i] <= asm_ext_ff;
					rxb_data_ff[i] <= asm_data_ff;
				end
			end
		end
	end

	// Receive error counter: frozen in listen modes, held while disabled
	assign count_en  = canmrx_tx_mode(cur_op_ff);
	assign rec_inc   = count_en && eng_rx_err && (rec_ff != 8'hFF);
	assign warn_rise = rec_inc && (rec_ff == WARN_LIMIT - 8'h01);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rec_ff <= 8'h00;
		else if (cur_op_ff == MODE_INIT)
			rec_ff <= 8'h00;
		else if (rec_inc)
			rec_ff <= rec_ff + 8'h01;
	end

	rec_step_a: assert property (rec_inc |=> (rec_ff == $past(rec_ff) + 8'h01))
		else $error("receive error count did not step");
	rec_freeze_a: assert property ((cur_op_ff == MODE_LISTEN) [*2] |-> $stable(rec_ff))
		else $error("error count moved in listen-only");

	// Wake watch with optional glitch filter
	assign wake_watch = (cur_op_ff == MODE_DISABLE) || cpu_sleep;
	assign wake_act   = wake_watch && !rx_s2_ff
		&& (!wake_filter_enable_ff || (wf_cnt_ff == WAKE_FILT_LAST));
	assign sleep_exit = sleep_d_ff && !cpu_sleep;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wf_cnt_ff <= 4'h0;
			sleep_d_ff <= 1'b0;
		end else begin
			sleep_d_ff <= cpu_sleep;
			if (!wake_watch || rx_s2_ff)
				wf_cnt_ff <= 4'h0;
			else if (wf_cnt_ff != WAKE_FILT_LAST)
				wf_cnt_ff <= wf_cnt_ff + 4'h1;
		end
	end

	// Status flags: a hardware set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxf_ff <= 2'h0;
			ovr_ff <= 2'h0;
			error_summary_flag_ff <= 1'b0;
			wake_flag_ff <= 1'b0;
			invalid_msg_flag_ff <= 1'b0;
		end else begin
			rxf_ff[0] <= load0 || (rxf_ff[0] && !(intf_wr && pwdata[INT_RX0]));
			rxf_ff[1] <= load1 || (rxf_ff[1] && !(intf_wr && pwdata[INT_RX1]));
			ovr_ff[0] <= set_ovr0 || (ovr_ff[0] && !(intf_wr && pwdata[INT_OVR0]));
			ovr_ff[1] <= set_ovr1 || (ovr_ff[1] && !(intf_wr && pwdata[INT_OVR1]));
			invalid_msg_flag_ff <= (active && eng_rx_err)
				|| (invalid_msg_flag_ff && !(intf_wr && pwdata[INT_IVR]));
			error_summary_flag_ff <= set_ovr0 || set_ovr1 || warn_rise || (active && eng_rx_err)
				|| (error_summary_flag_ff && !(intf_wr && pwdata[INT_ERR]));
			wake_flag_ff <= wake_act || sleep_exit
				|| (wake_flag_ff && !(intf_wr && pwdata[INT_WAKE]));
		end
	end

	sequence s_full0_hit;
		accept && hit0 && rxf_ff[0];
	endsequence

	ovr_single_a: assert property (s_full0_hit ##0 !double_buffer_enable_ff |=> ovr_ff[0] && error_summary_flag_ff
		&& !load1 && $stable(rxb_id_ff[0]))
		else $error("buffer zero overrun not flagged");
	dbl_spill_a: assert property (s_full0_hit ##0 (double_buffer_enable_ff && !rxf_ff[1]) |=> rxf_ff[1]
		&& (rxb_id_ff[1] == $past(asm_id_ff)) && !$rose(ovr_ff[0]))
		else $error("double buffer spill failed");
	rx_flag_a: assert property (accept && hit0 && !rxf_ff[0] |=> rxf_ff[0] ##1 rxf_ff[0])
		else $error("receive flag not raised after frame");
	wake_dis_a: assert property ((cur_op_ff == MODE_DISABLE) && !wake_filter_enable_ff && !rx_s2_ff
		|=> wake_flag_ff)
		else $error("wake flag missed in disable");

	assign rx0_irq  = rxf_ff[0] && inte_ff[0];
	assign rx1_irq  = rxf_ff[1] && inte_ff[1];
	assign err_irq  = error_summary_flag_ff && inte_ff[2];
	assign wake_irq = wake_flag_ff && inte_ff[3];

	// Transmit buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				for (int w = 0; w < 3; w++)
					txw_ff[i][w] <= 32'h0;
				tx_arb_ff[i] <= 16'h0;
				tx_pri_ff[i] <= 2'h0;
			end
			tx_req_ff <= 3'h0;
			tx_abt_ff <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (apb_wr && paddr[7:6] == TXB_HI && paddr[5:4] == 2'(i)) begin
					if (paddr[3:2] == 2'h0) begin
						tx_arb_ff[i] <= pwdata[TXC_ARB_LSB +: 16];
						tx_pri_ff[i] <= pwdata[1:0];
						tx_req_ff[i] <= pwdata[TXC_REQ];
						if (pwdata[TXC_REQ])
							tx_abt_ff[i] <= 1'b0;
					end else begin
						txw_ff[i][paddr[3:2] - 2'h1] <= pwdata;
					end
				end
				if (eng_tx_done && eng_tx_done_idx == 2'(i))
					tx_req_ff[i] <= 1'b0;
				if (abort_now && tx_req_ff[i]) begin
					tx_req_ff[i] <= 1'b0;
					tx_abt_ff[i] <= 1'b1;
				end
			end
		end
	end

	abort_hold_a: assert property (abort_now && tx_req_ff[0] |=> !tx_req_ff[0] && tx_abt_ff[0])
		else $error("held transmission not aborted");

	// Highest priority pending buffer, lowest index on a tie
	always_comb begin
		sel_v = 1'b0;
		sel_i = 2'h0;
		sel_p = 2'h0;
		for (int i = 0; i < 3; i++) begin
			if (tx_req_ff[i] && (!sel_v || tx_pri_ff[i] > sel_p)) begin
				sel_v = 1'b1;
				sel_i = 2'(i);
				sel_p = tx_pri_ff[i];
			end
		end
	end

	assign tx_sel_valid = sel_v && count_en;
	assign tx_sel_idx   = sel_i;
	assign tx_start_ok  = tx_sel_valid && !tx_hold_ff && bus_idle;

	prio_pick_a: assert property (tx_sel_valid && tx_req_ff[2]
		|-> tx_pri_ff[tx_sel_idx] >= tx_pri_ff[2])
		else $error("lower priority buffer offered");
endmodule : canmrx_top
`default_nettype wire

// ---- tb/canmrx_node_model.sv ----
// Purpose: far-side bus node on a wired-AND line
// Assumes: recessive is 1
// Notes:   dominant only while node_dom is high
`timescale 1ns/1ps
`default_nettype none
module canmrx_node_model (
	// Line
	input  wire logic dev_tx,
	input  wire logic dev_oe_n,
	input  wire logic node_dom,
	output logic      bus_rx
);
	// A released pin reads recessive
	assign bus_rx = !node_dom && (dev_oe_n || dev_tx);
endmodule : canmrx_node_model
`default_nettype wire

// ---- tb/canmrx_top_tb.sv ----
// Purpose: register-level tests of modes, receive and priority
// Assumes: zero-wait APB, engine pulses driven here
// Notes:   bit tick is ten clocks after reset
`timescale 1ns/1ps
`default_nettype none
module canmrx_top_tb;
	import canmrx_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, so, rxl, txo, oen, tcan, rcan;
	logic        nd, tb, rb, pas, we, ext, fd, re, sv, i0, i1, ie, iw, ok, se, sl;
	logic [7:0]  pa;
	logic [31:0] pw, pr, rd;
	logic [28:0] aid;
	logic [1:0]  si;
	int          errors, n_compared;
	canmrx_node_model i_canmrx_node_model (.dev_tx(txo), .dev_oe_n(oen), .node_dom(nd), .bus_rx(rxl));
	canmrx_top i_canmrx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(pa), .pwdata(pw), .prdata(pr), .pready(pready), .pslverr(so),
		.can_rx_pin(rxl), .can_tx_pin_o(txo), .can_tx_pin_oe_n(oen), .tx_pin_is_can(tcan),
		.rx_pin_is_can(rcan), .cpu_sleep(sl), .eng_tx_bit(tb), .eng_rx_bit(rb),
		.eng_passive(pas), .eng_asm_we(we), .eng_asm_id(aid), .eng_asm_ext(ext),
		.eng_asm_data(64'h0), .eng_frame_done(fd), .eng_rx_err(re), .eng_tx_done(1'b0),
		.eng_tx_done_idx(2'h0), .tx_sel_valid(sv), .tx_sel_idx(si), .tx_start_ok(ok),
		.rx0_irq(i0), .rx1_irq(i1), .err_irq(ie), .wake_irq(iw));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = !pclk;
	end
	task automatic report_and_stop;
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		pa     <= a;
		pw     <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = pr;
		se = so;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so two calls never drive psel twice at once
		@(posedge pclk);
	endtask : apb
	task automatic frame(input logic [28:0] id, input logic x, input logic err);
		we  <= 1'b1;
		aid <= id;
		ext <= x;
		@(posedge pclk);
		we <= 1'b0;
		@(posedge pclk);
		fd <= !err;
		re <= err;
		@(posedge pclk);
		fd <= 1'b0;
		re <= 1'b0;
		@(posedge pclk);
	endtask : frame
	initial begin
		{presetn, psel, penable, pwrite, nd, sl, we, ext, fd, re, pa, pw, aid} = '0;
		// Idle engine sends recessive
		tb = 1'b1;
		errors = 0;
		n_compared = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 8'hFC, 0);
		chk(32'(se), 1);
		apb(0, 8'h00, 0);
		chk(rd, 32'h00000480);
		apb(1, 8'h20, 32'h12340000);
		apb(1, 8'h38, 32'h1FFC0000);
		apb(1, 8'h0C, 32'h63);
		apb(1, 8'h00, 0);
		@(posedge pclk);
		chk(32'({tcan, oen, rcan}), 5);
		frame(29'h123400AB, 0, 0);
		chk(32'(i0), 1);
		apb(0, 8'h40, 0);
		chk(rd, 32'h123400AB);
		frame(29'h12340001, 0, 0);
		apb(0, 8'h08, 0);
		chk(rd, 32'h8021);
		frame(29'h02340000, 0, 0);
		apb(0, 8'h50, 0);
		chk(rd, 32'h02340000);
		apb(1, 8'h08, 32'hFFFF);
		apb(1, 8'h04, 32'h1009);
		repeat (2) frame(29'h12340000, 0, 0);
		apb(0, 8'h08, 0);
		chk(rd, 32'h3);
		frame(29'h12340000, 0, 0);
		apb(0, 8'h08, 0);
		chk(rd, 32'h4023);
		chk(32'({i1, ie}), 3);
		apb(1, 8'h08, 32'hFFFF);
		frame(29'h12340000, 1, 0);
		frame(0, 0, 1);
		apb(0, 8'h08, 0);
		chk(rd, 32'hA0);
		apb(1, 8'h00, 32'h300);
		apb(0, 8'h00, 0);
		chk(rd, 32'h300);
		repeat (150) @(posedge pclk);
		frame(0, 0, 1);
		apb(0, 8'h10, 0);
		chk(rd, 32'h1);
		chk(32'({tcan, oen, rcan, pas}), 7);
		apb(1, 8'h00, 32'h100);
		repeat (150) @(posedge pclk);
		apb(1, 8'h08, 32'hFFFF);
		nd <= 1'b1;
		repeat (10) @(posedge pclk);
		nd <= 1'b0;
		apb(0, 8'h08, 0);
		chk(rd, 32'h40);
		chk(32'(iw), 1);
		apb(0, 8'h00, 0);
		chk(rd, 32'h120);
		chk(32'({tcan, rcan}), 0);
		apb(1, 8'h00, 32'h200);
		apb(1, 8'h80, 32'h9);
		apb(1, 8'h90, 32'hB);
		apb(1, 8'hA0, 32'hA);
		chk(32'({sv, si, rb, tcan, rcan}), 32'h2C);
		chk(32'(ok), 0);
		apb(1, 8'h00, 32'h100);
		@(posedge pclk);
		apb(0, 8'h80, 0);
		chk(rd & 32'h4B, 32'h41);
		apb(1, 8'h00, 32'h700);
		repeat (150) @(posedge pclk);
		frame(29'h55, 0, 1);
		apb(0, 8'h40, 0);
		chk(rd, 32'h55);
		apb(1, 8'h08, 32'hFFFF);
		sl <= 1'b1;
		@(posedge pclk);
		sl <= 1'b0;
		@(posedge pclk);
		apb(0, 8'h08, 0);
		chk(rd, 32'h40);
		report_and_stop();
	end
	// Whole run needs under two thousand clocks
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
endmodule : canmrx_top_tb
`default_nettype wire
